//--- inc/cmv_params.svh
`ifndef CMV_PARAMS_SVH
`define CMV_PARAMS_SVH

// Register byte offsets
`define CMV_OFS_CFG        8'h00
`define CMV_OFS_REF        8'h04
`define CMV_OFS_STAT       8'h08
`define CMV_OFS_PSC        8'h0c

// Gate and sync configuration fields
`define CMV_CFG_SYNC_BIT   0
`define CMV_CFG_GSS_BIT    1
`define CMV_CFG_RESET      8'h02
`define CMV_CFG_WMASK      8'h03

// Reference ladder control fields
`define CMV_REF_EN_BIT     7
`define CMV_REF_RNG_BIT    5
`define CMV_REF_LVL_MSB    3
`define CMV_REF_RESET      8'h00
`define CMV_REF_WMASK      8'haf

// Prescaler select register
`define CMV_PSC_RESET      2'h0

// Ladder code in 1/96 supply steps
`define CMV_CODE_QUARTER   7'h18
`define CMV_CODE_LO_STEP   7'h04
`define CMV_CODE_HI_STEP   7'h03

`endif

//--- inc/cmv_pkg.sv
package cmv_pkg;

	// Timer clock prescale ratio
	typedef enum logic [1:0] {
		CMV_DIV1 = 2'h0,
		CMV_DIV2 = 2'h1,
		CMV_DIV4 = 2'h2,
		CMV_DIV8 = 2'h3
	} cmv_presc_t;

	// Software settings seen by the sync core
	typedef struct packed {
		logic       sync_sel;
		logic       gate_sel;
		cmv_presc_t presc;
	} cmv_cfg_t;

endpackage : cmv_pkg

//--- inc/cmv_sync_if.sv
`timescale 1ns/1ps
// Link between register bank and timer sync core
interface cmv_sync_if;
	cmv_pkg::cmv_cfg_t cfg;         // Live configuration
	logic              cmp_lvl;     // Synchronised comparator level
	logic              gpin_lvl;    // Synchronised external gate pin
	logic              tclk_lvl;    // Synchronised timer clock source
	logic              gate;        // Gate towards the timer
	logic              cmp_fwd;     // Comparator level forwarded downstream
	logic              cmp_latch;   // Falling-edge latched comparator
	logic              inc;         // One-cycle count pulse

	modport bank (output cfg, cmp_lvl, gpin_lvl, tclk_lvl,
	              input  gate, cmp_fwd, cmp_latch, inc);
	modport core (input  cfg, cmp_lvl, gpin_lvl, tclk_lvl,
	              output gate, cmp_fwd, cmp_latch, inc);
endinterface : cmv_sync_if

//--- hw/cmv_sync.sv
`timescale 1ns/1ps
// Prescaler, falling-edge comparator latch and gate select
module cmv_sync (
	input  wire logic hclk,
	input  wire logic hresetn,
	cmv_sync_if.core  sif
);

	logic       tclk_prev_q;     // Timer clock one cycle ago
	logic       tclk_prev_d;
	logic [2:0] ps_cnt_q;        // Prescaler counter
	logic [2:0] ps_cnt_d;
	logic       pclk_q;          // Prescaled clock, registered
	logic       pclk_d;
	logic       latch_q;         // Latched comparator level
	logic       latch_d;
	logic       fwd_q;           // Forwarded comparator level
	logic       fwd_d;
	logic       gate_q;          // Gate towards the timer
	logic       gate_d;
	logic       inc_q;           // Count pulse
	logic       inc_d;
	logic       tclk_rise;       // Rising edge of raw timer clock
	logic       pclk_rise;       // Rising edge after prescaler
	logic       pclk_fall;       // Falling edge after prescaler

	// Next-state logic for the whole core
	always_comb begin
		tclk_prev_d = sif.tclk_lvl;
		tclk_rise   = sif.tclk_lvl & ~tclk_prev_q;
		ps_cnt_d    = tclk_rise ? ps_cnt_q + 3'h1 : ps_cnt_q;
		unique case (sif.cfg.presc)
			cmv_pkg::CMV_DIV1: pclk_d = sif.tclk_lvl;
			cmv_pkg::CMV_DIV2: pclk_d = ps_cnt_q[0];
			cmv_pkg::CMV_DIV4: pclk_d = ps_cnt_q[1];
			cmv_pkg::CMV_DIV8: pclk_d = ps_cnt_q[2];
		endcase
		pclk_rise = pclk_d & ~pclk_q;
		pclk_fall = ~pclk_d & pclk_q;
		latch_d = pclk_fall ? sif.cmp_lvl : latch_q;
		fwd_d = sif.cfg.sync_sel ? latch_d : sif.cmp_lvl;
		gate_d = sif.cfg.gate_sel ? sif.gpin_lvl : fwd_d;
		inc_d = pclk_rise & gate_q;
	end

	// State registers; comparator latch starts low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tclk_prev_q <= 1'b0;
			ps_cnt_q    <= 3'h0;
			pclk_q      <= 1'b0;
			latch_q     <= 1'b0;
			fwd_q       <= 1'b0;
			gate_q      <= 1'b0;
			inc_q       <= 1'b0;
		end else begin
			tclk_prev_q <= tclk_prev_d;
			ps_cnt_q    <= ps_cnt_d;
			pclk_q      <= pclk_d;
			latch_q     <= latch_d;
			fwd_q       <= fwd_d;
			gate_q      <= gate_d;
			inc_q       <= inc_d;
		end
	end

	// Results leave straight from flops
	assign sif.gate      = gate_q;
	assign sif.cmp_fwd   = fwd_q;
	assign sif.cmp_latch = latch_q;
	assign sif.inc       = inc_q;

endmodule : cmv_sync

//--- hw/cmv_top.sv
`timescale 1ns/1ps
`include "cmv_params.svh"

module cmv_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave port
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Asynchronous pins
	input  wire logic        comparator_out,
	input  wire logic        external_gate_pin,
	input  wire logic        timer_clk_src,
	// Timer side
	output logic             timer_gate,
	output logic             timer_inc,
	output logic             cmp_sync_out,
	// Reference ladder side
	output logic             ref_ladder_enable,
	output logic             ref_range_select,
	output logic [3:0]       ref_level_field,
	output logic             ref_ground_clamp,
	output logic [6:0]       ref_code
);

	localparam int NPIN = 3;            // Pins needing synchronisers

	// Synchroniser chains, one per pin
	logic [NPIN-1:0] pin_raw;           // Raw pin levels
	logic [NPIN-1:0] pin_meta_q;        // First stage, read by second only
	logic [NPIN-1:0] pin_sync_q;        // Second stage, safe to use

	// Bus address phase capture
	logic            aph_valid_q;       // Data phase pending
	logic            aph_valid_d;
	logic            aph_write_q;       // Pending access is a write
	logic            aph_write_d;
	logic [7:0]      aph_addr_q;        // Pending low address byte
	logic [7:0]      aph_addr_d;
	logic            take;              // Address phase accepted now
	logic [7:0]      rd_addr;           // Address of a read being taken

	// Register storage
	logic [7:0]      cfg_q;             // Gate and sync configuration
	logic [7:0]      cfg_d;
	logic [7:0]      ref_q;             // Reference ladder control
	logic [7:0]      ref_d;
	logic [1:0]      psc_q;             // Prescaler ratio select
	logic [1:0]      psc_d;

	// Answer and output flops
	logic [31:0]     hrdata_q;
	logic [31:0]     hrdata_d;
	logic            hresp_q;
	logic            hreadyout_q;
	logic            ref_en_q;
	logic            ref_en_d;
	logic            ref_rng_q;
	logic            ref_rng_d;
	logic [3:0]      ref_lvl_q;
	logic [3:0]      ref_lvl_d;
	logic            ref_clamp_q;
	logic            ref_clamp_d;
	logic [6:0]      ref_code_q;
	logic [6:0]      ref_code_d;
	logic [7:0]      stat_val;          // Live status byte

	// Sync core link
	cmv_sync_if sif ();

	assign pin_raw = {timer_clk_src, external_gate_pin, comparator_out};

	// Two-flop synchronisers for every pin
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			// Pins toggle with no relation to hclk
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					pin_meta_q[gi] <= 1'b0;
					pin_sync_q[gi] <= 1'b0;
				end else begin
					pin_meta_q[gi] <= pin_raw[gi];
					pin_sync_q[gi] <= pin_meta_q[gi];
				end
			end
		end
	endgenerate

	// Feed the sync core
	assign sif.cmp_lvl        = pin_sync_q[0];
	assign sif.gpin_lvl       = pin_sync_q[1];
	assign sif.tclk_lvl       = pin_sync_q[2];
	assign sif.cfg.sync_sel   = cfg_q[`CMV_CFG_SYNC_BIT];
	assign sif.cfg.gate_sel   = cfg_q[`CMV_CFG_GSS_BIT];
	assign sif.cfg.presc      = cmv_pkg::cmv_presc_t'(psc_q);

	// Prescaler, latch and gate select
	cmv_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.sif     (sif)
	);

	// Address phase decode; zero wait states, so hready is ours
	always_comb begin
		take        = hsel & hready & htrans[1];
		aph_valid_d = take;
		aph_write_d = take ? hwrite : aph_write_q;
		aph_addr_d  = take ? haddr[7:0] : aph_addr_q;
		rd_addr     = {haddr[7:2], 2'b00};
	end

	// Address phase registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aph_valid_q <= 1'b0;
			aph_write_q <= 1'b0;
			aph_addr_q  <= 8'h00;
		end else begin
			aph_valid_q <= aph_valid_d;
			aph_write_q <= aph_write_d;
			aph_addr_q  <= aph_addr_d;
		end
	end

	// Register writes land in the data phase
	always_comb begin
		cfg_d = cfg_q;
		ref_d = ref_q;
		psc_d = psc_q;
		if (aph_valid_q && aph_write_q) begin
			unique case ({aph_addr_q[7:2], 2'b00})
				// Masked write, spare bits stay zero
				`CMV_OFS_CFG: cfg_d = hwdata[7:0] & `CMV_CFG_WMASK;
				`CMV_OFS_REF: ref_d = hwdata[7:0] & `CMV_REF_WMASK;
				`CMV_OFS_PSC: psc_d = hwdata[1:0];
				// Status and unmapped words ignore writes
				default: ;
			endcase
		end
	end

	// Register storage flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg_q <= `CMV_CFG_RESET;
			ref_q <= `CMV_REF_RESET;
			psc_q <= `CMV_PSC_RESET;
		end else begin
			cfg_q <= cfg_d;
			ref_q <= ref_d;
			psc_q <= psc_d;
		end
	end

	// Status byte: live view of the sync core
	assign stat_val = {4'h0, sif.inc, sif.gate, sif.cmp_fwd, sif.cmp_latch};

	// Read data is fetched in the address phase so it leaves a flop;
	// the _d values forward a write still in its data phase
	always_comb begin
		hrdata_d = hrdata_q;
		if (take && !hwrite) begin
			unique case (rd_addr)
				// Unused bits read back as zero
				`CMV_OFS_CFG:  hrdata_d = {24'h000000, cfg_d};
				`CMV_OFS_REF:  hrdata_d = {24'h000000, ref_d};
				`CMV_OFS_STAT: hrdata_d = {24'h000000, stat_val};
				`CMV_OFS_PSC:  hrdata_d = {30'h00000000, psc_d};
				// Unmapped reads answer zero with OKAY
				default:       hrdata_d = 32'h00000000;
			endcase
		end
	end

	// Reference ladder outputs
	always_comb begin
		ref_en_d    = ref_q[`CMV_REF_EN_BIT];
		ref_clamp_d = ~ref_q[`CMV_REF_EN_BIT];
		ref_rng_d   = ref_q[`CMV_REF_RNG_BIT];
		ref_lvl_d   = ref_q[`CMV_REF_LVL_MSB:0];
		// Ladder code in 1/96 supply steps
		if (!ref_q[`CMV_REF_EN_BIT]) begin
			ref_code_d = 7'h00;
		end else if (ref_q[`CMV_REF_RNG_BIT]) begin
			ref_code_d = 7'(ref_lvl_d * `CMV_CODE_LO_STEP);
		end else begin
			ref_code_d = 7'(`CMV_CODE_QUARTER + ref_lvl_d * `CMV_CODE_HI_STEP);
		end
	end

	// Answer and ladder flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q    <= 32'h00000000;
			hresp_q     <= 1'b0;
			hreadyout_q <= 1'b1;
			ref_en_q    <= 1'b0;
			ref_rng_q   <= 1'b0;
			ref_lvl_q   <= 4'h0;
			ref_clamp_q <= 1'b1;
			ref_code_q  <= 7'h00;
		end else begin
			hrdata_q    <= hrdata_d;
			// Always OKAY, never stalls
			hresp_q     <= 1'b0;
			hreadyout_q <= 1'b1;
			ref_en_q    <= ref_en_d;
			ref_rng_q   <= ref_rng_d;
			ref_lvl_q   <= ref_lvl_d;
			ref_clamp_q <= ref_clamp_d;
			ref_code_q  <= ref_code_d;
		end
	end

	// Port drive, all from flops
	assign hrdata            = hrdata_q;
	assign hresp             = hresp_q;
	assign hreadyout         = hreadyout_q;
	assign timer_gate        = sif.gate;
	assign timer_inc         = sif.inc;
	assign cmp_sync_out      = sif.cmp_fwd;
	assign ref_ladder_enable = ref_en_q;
	assign ref_range_select  = ref_rng_q;
	assign ref_level_field   = ref_lvl_q;
	assign ref_ground_clamp  = ref_clamp_q;
	assign ref_code          = ref_code_q;

endmodule : cmv_top

//--- tb/cmv_top_assertions.sv
`timescale 1ns/1ps
// Bus, reference ladder and count pulse checks, top ports only
module cmv_top_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	input wire logic        timer_inc,
	input wire logic        ref_ladder_enable,
	input wire logic        ref_range_select,
	input wire logic [3:0]  ref_level_field,
	input wire logic        ref_ground_clamp,
	input wire logic [6:0]  ref_code
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read address phase taken at one offset
	sequence s_rd(logic [7:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
	endsequence
	// Zero-wait slave, always OKAY
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("bus stalled or errored");
	// Data phase shows zeros in unimplemented bits
	cfg_zero_a: assert property (s_rd(8'h00) |=> hrdata[31:2] == 30'h0)
		else $error("config read has stray bits");
	ref_zero_a: assert property (s_rd(8'h04) |=> hrdata[31:8] == 24'h0 && !hrdata[6] && !hrdata[4])
		else $error("reference read has stray bits");
	// Read data holds unless a read is taken
	rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	ladder_clamp_a: assert property (ref_ground_clamp == !ref_ladder_enable)
		else $error("clamp disagrees with enable");
	off_code_a: assert property (!ref_ladder_enable |-> ref_code == 7'h00)
		else $error("disabled ladder not at ground");
	low_code_a: assert property (ref_ladder_enable && ref_range_select |-> ref_code == {1'b0, ref_level_field, 2'b00})
		else $error("low range code wrong");
	high_code_a: assert property (ref_ladder_enable && !ref_range_select |-> ref_code == 7'h18 + {3'h0, ref_level_field} * 7'h03)
		else $error("high range code wrong");
	// Count pulse is single; timer clock levels span two cycles or more
	inc_pulse_a: assert property (timer_inc |=> !timer_inc [*3])
		else $error("count pulses too close");
endmodule : cmv_top_assertions

bind cmv_top cmv_top_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
	.hreadyout, .hrdata, .hresp, .timer_inc, .ref_ladder_enable, .ref_range_select,
	.ref_level_field, .ref_ground_clamp, .ref_code);

//--- tb/cmv_far_model.sv
`timescale 1ns/1ps
// Comparator output, gate pin and raw timer clock
module cmv_far_model (
	input  wire logic hclk,
	output logic      comparator_out,
	output logic      external_gate_pin,
	output logic      timer_clk_src
);
	// Timer clock stands low outside bursts
	initial begin
		comparator_out = 1'b0;
		external_gate_pin = 1'b0;
		timer_clk_src = 1'b0;
	end
	// Raw clock periods, h cycles per level; small h is the fast case
	task automatic pulse(input int n, input int h);
		repeat (n) begin
			@(posedge hclk) timer_clk_src <= 1'b1;
			repeat (h) @(posedge hclk);
			timer_clk_src <= 1'b0;
			repeat (h - 1) @(posedge hclk);
		end
	endtask : pulse
	task automatic set_clk(input logic v);
		@(posedge hclk) timer_clk_src <= v;
	endtask : set_clk
	task automatic set_cmp(input logic v);
		@(posedge hclk) comparator_out <= v;
	endtask : set_cmp
	task automatic set_pin(input logic v);
		@(posedge hclk) external_gate_pin <= v;
	endtask : set_pin
endmodule : cmv_far_model

//--- tb/tb_cmv_top.sv
`timescale 1ns/1ps
// Register, ladder and timer gate tests
module tb_cmv_top;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;         // Transfer size, always a whole word
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        cmp, gpin, tclk, gate, inc, fwd, en, rng, clamp;
	logic [3:0]  lvl;
	logic [6:0]  code;
	logic [31:0] rd;
	int          miscompares, num_checks, n_inc, n, lv, rg;

	cmv_far_model far_u (.hclk(hclk), .comparator_out(cmp), .external_gate_pin(gpin),
		.timer_clk_src(tclk));
	cmv_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .comparator_out(cmp),
		.external_gate_pin(gpin), .timer_clk_src(tclk), .timer_gate(gate), .timer_inc(inc),
		.cmp_sync_out(fwd), .ref_ladder_enable(en), .ref_range_select(rng),
		.ref_level_field(lvl), .ref_ground_clamp(clamp), .ref_code(code));

	// 25 MHz clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	// Count timer pulses
	always @(posedge hclk) begin
		if (inc === 1'b1) n_inc++;
	end
	// Address phase held until hready
	task automatic ahb_addr(input logic [7:0] a, input logic wr);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask : ahb_addr
	task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
		ahb_addr(a, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : ahb_wr
	task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
		ahb_addr(a, 1'b0);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : ahb_rd
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done
	// Hang guard, well beyond the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		test_done;
	end

	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{miscompares, num_checks, n_inc} = '0;
		hsize = 3'h2;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		ahb_rd(8'h00, rd);
		chk("cfg reset", rd, 32'h2);
		ahb_rd(8'h04, rd);
		chk("ref reset", rd, 32'h0);
		chk("clamp reset", {31'h0, clamp}, 32'h1);
		ahb_wr(8'h00, 32'hffff_fffc);
		ahb_rd(8'h00, rd);
		chk("cfg mask", rd, 32'h0);
		ahb_wr(8'h04, 32'hffff_ff50);
		ahb_rd(8'h04, rd);
		chk("ref mask", rd, 32'h0);
		ahb_rd(8'h10, rd);
		chk("unmapped", rd, 32'h0);
		// Every level in both ranges
		for (rg = 0; rg < 2; rg++) begin
			for (lv = 0; lv < 16; lv++) begin
				ahb_wr(8'h04, 32'(8'h80 + rg * 32 + lv));
				ahb_rd(8'h04, rd);
				chk("ref back", rd, 32'(8'h80 + rg * 32 + lv));
				chk("level out", {28'h0, lvl}, 32'(lv));
				chk("range out", {31'h0, rng}, 32'(rg));
				chk("ref code", {25'h0, code}, rg ? 32'(lv * 4) : 32'(24 + lv * 3));
			end
		end
		ahb_wr(8'h04, 32'h20);
		ahb_rd(8'h04, rd);
		chk("clamp on", {31'h0, clamp}, 32'h1);
		chk("off code", {25'h0, code}, 32'h0);
		ahb_wr(8'h04, 32'ha7);
		// Gate from pin, every prescale ratio
		ahb_wr(8'h00, 32'h2);
		far_u.set_pin(1'b1);
		repeat (6) @(posedge hclk);
		chk("gate pin", {31'h0, gate}, 32'h1);
		for (n = 0; n < 4; n++) begin
			ahb_wr(8'h0c, 32'(n));
			n_inc = 0;
			far_u.pulse(16, 4);
			repeat (8) @(posedge hclk);
			chk("inc count", n_inc, 32'(16 >> n));
		end
		far_u.set_pin(1'b0);
		repeat (6) @(posedge hclk);
		n_inc = 0;
		far_u.pulse(4, 2);
		repeat (8) @(posedge hclk);
		chk("inc gated", n_inc, 32'h0);
		ahb_wr(8'h0c, 32'h0);
		// Comparator gate, pass-through mode
		ahb_wr(8'h00, 32'h0);
		far_u.set_cmp(1'b1);
		repeat (6) @(posedge hclk);
		chk("async fwd", {31'h0, fwd}, 32'h1);
		chk("gate cmp", {31'h0, gate}, 32'h1);
		// Latched mode: moves only on a falling timer clock
		ahb_wr(8'h00, 32'h1);
		far_u.set_cmp(1'b0);
		far_u.pulse(1, 4);
		repeat (6) @(posedge hclk);
		chk("latch low", {31'h0, fwd}, 32'h0);
		far_u.set_clk(1'b1);
		far_u.set_cmp(1'b1);
		repeat (8) @(posedge hclk);
		chk("latch held", {31'h0, fwd}, 32'h0);
		far_u.set_clk(1'b0);
		repeat (6) @(posedge hclk);
		chk("latch new", {31'h0, fwd}, 32'h1);
		chk("gate sync", {31'h0, gate}, 32'h1);
		chk("ref kept", {25'h0, code}, 32'h1c);
		// Status: latched, forwarded and gate high, no count pulse
		ahb_rd(8'h08, rd);
		chk("status", rd, 32'h7);
		test_done;
	end
endmodule : tb_cmv_top
